// [core/pattern_output_unit.sv]
// Top level: timed pattern output unit with Avalon-MM register slave
// Contract
// - Pin carries pattern output only when direction and pattern enable are 1 (code: a direction-1 pin shows the trigger-loaded latch whatever the enable).
// - On enable, pin first drives its current output latch contents.
// - Selected trigger copies the group's staged bits into its output latches.
// - Enable 1 and direction 0: input pin, latch read-only yet still loaded.
// - Staged-to-latch copy happens at every trigger, whatever the pin function.
// - Timer, DMA or address output on a pin suppresses the pattern output.
// - Non-overlap mode: match A copies every staged bit of the group.
// - Non-overlap mode: match B copies only staged bits that are 0.
// - Input capture on register A triggers the transfer like a match.
// - Normal mode: group outputs change only at match A of its channel.
// - Non-overlap: register B sets trigger period, A sets margin.
// - Select 00 channel 0, 01 channel 1, 1x channel 2 (reset).
//
// The address map and the Avalon-MM register port are this design's own decisions.
`default_nettype none
module pattern_output_unit
#(
  parameter int PINS = 16
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Avalon-MM slave
  input  wire logic [3:0]       address,
  input  wire logic             read,
  input  wire logic             write,
  input  wire logic [31:0]      writedata,
  input  wire logic [3:0]       byteenable,
  output var  logic [31:0]      readdata,
  output var  logic             waitrequest,
  // Timer events, one bit per channel; match_a also pulses on capture A
  input  wire logic [2:0]       match_a,
  input  wire logic [2:0]       match_b,
  // Pins
  input  wire logic [PINS-1:0]  pin_in,
  output var  logic [PINS-1:0]  pin_out,
  output var  logic [PINS-1:0]  pin_oe,
  // Pins taken by timer, DMA or address output
  input  wire logic [PINS-1:0]  alt_func_en,
  output var  logic [PINS-1:0]  pattern_active
);
  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [15:0] port_b_direction_reg;  // bits 15:8 port B, 7:0 port A
  logic [15:0] pattern_enable_reg;
  logic [15:0] out_latch_reg;
  logic [15:0] out_latch_next;
  logic [15:0] staged_reg;
  logic [7:0]  trigger_select_reg;
  logic [7:0]  overlap_mode_reg;
  logic        ack_reg;
  logic [31:0] readdata_next;
  logic [3:0]  load_all;
  logic [3:0]  load_zero;

  // --------------------------------------------------------------------------
  // Group trigger decoders
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < pattern_output_pkg::GROUPS; gi++)
    begin : g_grp
      pattern_group_if gif ();
      assign gif.trig_sel   = trigger_select_reg[2*gi +: 2];
      assign gif.nonoverlap = overlap_mode_reg[gi];
      assign gif.match_a    = match_a;
      assign gif.match_b    = match_b;
      assign load_all[gi]   = gif.load_all;
      assign load_zero[gi]  = gif.load_zero;
      pattern_group_trigger u_trig (.g(gif.grp));
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire logic       wr_go;
  wire logic [7:0] wb;
  wire logic [7:0] sw_dir_a;
  wire logic [7:0] sw_dir_b;
  wire logic [7:0] sw_latch_a;
  wire logic [7:0] sw_latch_b;
  wire logic [7:0] sw_en_a;
  wire logic [7:0] sw_en_b;
  wire logic [7:0] sw_stg_a;
  wire logic [7:0] sw_stg_b;
  wire logic       sw_tsel;
  wire logic       sw_mode;
  // One wait state per access: the answer lands on the second edge
  assign wr_go       = write & ack_reg;
  assign wb          = byteenable[0] ? writedata[7:0] : pattern_output_pkg::BYTE_ZERO;
  assign sw_dir_a    = {8{wr_go & byteenable[0] & (address == pattern_output_pkg::ADDR_DIR_A)}};
  assign sw_dir_b    = {8{wr_go & byteenable[0] & (address == pattern_output_pkg::ADDR_DIR_B)}};
  assign sw_en_a     = {8{wr_go & byteenable[0] &
                          (address == pattern_output_pkg::ADDR_LOW_ENABLE)}};
  assign sw_en_b     = {8{wr_go & byteenable[0] &
                          (address == pattern_output_pkg::ADDR_HIGH_ENABLE)}};
  assign sw_stg_a    = {8{wr_go & byteenable[0] &
                          (address == pattern_output_pkg::ADDR_LOW_STAGED)}};
  assign sw_stg_b    = {8{wr_go & byteenable[0] &
                          (address == pattern_output_pkg::ADDR_HIGH_STAGED)}};
  // Latch bit is read-only while its pattern enable is set
  assign sw_latch_a  = {8{wr_go & byteenable[0] & (address == pattern_output_pkg::ADDR_LATCH_A)}}
                       & ~pattern_enable_reg[7:0];
  assign sw_latch_b  = {8{wr_go & byteenable[0] & (address == pattern_output_pkg::ADDR_LATCH_B)}}
                       & ~pattern_enable_reg[15:8];
  assign sw_tsel     = wr_go & byteenable[0] & (address == pattern_output_pkg::ADDR_TRIG_SEL);
  assign sw_mode     = wr_go & byteenable[0] & (address == pattern_output_pkg::ADDR_OVERLAP_MODE);

  // --------------------------------------------------------------------------
  // Latch update
  // --------------------------------------------------------------------------
  // Trigger copy wins over a simultaneous software write to the same bit
  genvar bi;
  generate
    for (bi = 0; bi < PINS; bi++)
    begin : g_bit
      localparam int GRP = bi / pattern_output_pkg::GROUP_W;
      wire logic sw_bit;
      assign sw_bit = (bi < 8) ? sw_latch_a[bi % 8] : sw_latch_b[bi % 8];
      // Copy regardless of direction or pin function
      assign out_latch_next[bi] =
        load_all[GRP] ? staged_reg[bi] :
        (load_zero[GRP] & ~staged_reg[bi]) ? 1'b0 :
        sw_bit ? wb[bi % 8] : out_latch_reg[bi];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  always_comb
  begin
    readdata_next = 32'h0000_0000;
    case (address)
      pattern_output_pkg::ADDR_DIR_A:        readdata_next[7:0]  = port_b_direction_reg[7:0];
      pattern_output_pkg::ADDR_DIR_B:        readdata_next[7:0]  = port_b_direction_reg[15:8];
      pattern_output_pkg::ADDR_LATCH_A:      readdata_next[7:0]  = out_latch_reg[7:0];
      pattern_output_pkg::ADDR_LATCH_B:      readdata_next[7:0]  = out_latch_reg[15:8];
      pattern_output_pkg::ADDR_LOW_ENABLE:   readdata_next[7:0]  = pattern_enable_reg[7:0];
      pattern_output_pkg::ADDR_HIGH_ENABLE:  readdata_next[7:0]  = pattern_enable_reg[15:8];
      pattern_output_pkg::ADDR_LOW_STAGED:   readdata_next[7:0]  = staged_reg[7:0];
      pattern_output_pkg::ADDR_HIGH_STAGED:  readdata_next[7:0]  = staged_reg[15:8];
      pattern_output_pkg::ADDR_TRIG_SEL:     readdata_next[7:0]  = trigger_select_reg;
      pattern_output_pkg::ADDR_OVERLAP_MODE: readdata_next[7:0]  = overlap_mode_reg;
      pattern_output_pkg::ADDR_PIN_STATE:    readdata_next[15:0] = pin_in;
      pattern_output_pkg::ADDR_ALT_FUNC:     readdata_next[15:0] = alt_func_en;
      default:                               readdata_next       = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_reg     <= 1'b0;
      readdata    <= 32'h0000_0000;
      waitrequest <= 1'b1;
    end
    else
    begin
      ack_reg     <= (read | write) & ~ack_reg;
      waitrequest <= ~((read | write) & ~ack_reg);
      readdata    <= readdata_next;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port_b_direction_reg <= pattern_output_pkg::WORD_ZERO;
      pattern_enable_reg   <= pattern_output_pkg::WORD_ZERO;
      staged_reg           <= pattern_output_pkg::WORD_ZERO;
      trigger_select_reg   <= pattern_output_pkg::TRIG_SEL_RST;
      overlap_mode_reg     <= pattern_output_pkg::OVERLAP_MODE_RST;
    end
    else
    begin
      port_b_direction_reg <= ({sw_dir_b, sw_dir_a} & {wb, wb}) |
                              (~{sw_dir_b, sw_dir_a} & port_b_direction_reg);
      pattern_enable_reg   <= ({sw_en_b, sw_en_a} & {wb, wb}) |
                              (~{sw_en_b, sw_en_a} & pattern_enable_reg);
      staged_reg           <= ({sw_stg_b, sw_stg_a} & {wb, wb}) |
                              (~{sw_stg_b, sw_stg_a} & staged_reg);
      if (sw_tsel)
        trigger_select_reg <= wb;
      if (sw_mode)
        overlap_mode_reg   <= wb | pattern_output_pkg::OVERLAP_RSVD;
    end
  end

  // --------------------------------------------------------------------------
  // Output latch and pins
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_latch_reg  <= pattern_output_pkg::WORD_ZERO;
      pin_out        <= pattern_output_pkg::WORD_ZERO;
      pin_oe         <= pattern_output_pkg::WORD_ZERO;
      pattern_active <= pattern_output_pkg::WORD_ZERO;
    end
    else
    begin
      out_latch_reg  <= out_latch_next;
      // Pin always shows the latch; enabling adds no new value
      pin_out        <= out_latch_next;
      pin_oe         <= port_b_direction_reg & ~alt_func_en;
      pattern_active <= port_b_direction_reg & pattern_enable_reg & ~alt_func_en;
    end
  end
endmodule : pattern_output_unit
`default_nettype wire

// [core/pattern_output_pkg.sv]
// Package: register map, field layout and reset values of the pattern output unit
`default_nettype none
package pattern_output_pkg;
  // Avalon word addresses (byte address = 4 * index)
  localparam logic [3:0] ADDR_DIR_A        = 4'h0;
  localparam logic [3:0] ADDR_DIR_B        = 4'h1;
  localparam logic [3:0] ADDR_LATCH_A      = 4'h2;
  localparam logic [3:0] ADDR_LATCH_B      = 4'h3;
  localparam logic [3:0] ADDR_LOW_ENABLE   = 4'h4;
  localparam logic [3:0] ADDR_HIGH_ENABLE  = 4'h5;
  localparam logic [3:0] ADDR_LOW_STAGED   = 4'h6;
  localparam logic [3:0] ADDR_HIGH_STAGED  = 4'h7;
  localparam logic [3:0] ADDR_TRIG_SEL     = 4'h8;
  localparam logic [3:0] ADDR_OVERLAP_MODE = 4'h9;
  localparam logic [3:0] ADDR_PIN_STATE    = 4'hA;
  localparam logic [3:0] ADDR_ALT_FUNC     = 4'hB;
  localparam int         ADDR_W            = 4;
  // Reset values
  localparam logic [7:0] TRIG_SEL_RST      = 8'hFF;
  localparam logic [7:0] OVERLAP_MODE_RST  = 8'hF0;
  localparam logic [7:0] OVERLAP_RSVD      = 8'hF0;
  localparam logic [7:0] BYTE_ZERO         = 8'h00;
  localparam logic [15:0] WORD_ZERO        = 16'h0000;
  // Trigger select codes
  localparam logic [1:0] SEL_CH0           = 2'h0;
  localparam logic [1:0] SEL_CH1           = 2'h1;
  localparam int         GROUPS            = 4;
  localparam int         GROUP_W           = 4;
  localparam int         CHANNELS          = 3;
  localparam int         CH2               = 2;
endpackage : pattern_output_pkg
`default_nettype wire

// [core/pattern_group_if.sv]
// Interface: trigger inputs and mode of one pattern output group
`default_nettype none
interface pattern_group_if;
  logic [1:0] trig_sel;
  logic       nonoverlap;
  logic [2:0] match_a;
  logic [2:0] match_b;
  logic       load_all;
  logic       load_zero;
  modport top (output trig_sel, output nonoverlap, output match_a, output match_b,
               input load_all, input load_zero);
  modport grp (input trig_sel, input nonoverlap, input match_a, input match_b,
               output load_all, output load_zero);
endinterface : pattern_group_if
`default_nettype wire

// [core/pattern_group_trigger.sv]
// Trigger decoder for one four-bit pattern output group
`default_nettype none
module pattern_group_trigger
(
  pattern_group_if.grp g
);
  // --------------------------------------------------------------------------
  // Channel selection
  // --------------------------------------------------------------------------
  wire logic sel_a;
  wire logic sel_b;
  assign sel_a = (g.trig_sel == pattern_output_pkg::SEL_CH0) ? g.match_a[0] :
                 (g.trig_sel == pattern_output_pkg::SEL_CH1) ? g.match_a[1] :
                 g.match_a[pattern_output_pkg::CH2];
  assign sel_b = (g.trig_sel == pattern_output_pkg::SEL_CH0) ? g.match_b[0] :
                 (g.trig_sel == pattern_output_pkg::SEL_CH1) ? g.match_b[1] :
                 g.match_b[pattern_output_pkg::CH2];
  // Match A also carries input capture A; B only acts in non-overlap mode
  assign g.load_all  = sel_a;
  assign g.load_zero = g.nonoverlap & sel_b & ~sel_a;
endmodule : pattern_group_trigger
`default_nettype wire

// [verification/pattern_output_unit_props.sv]
// Port checks of the pattern output unit
`default_nettype none
module pattern_output_unit_props
#(
  parameter int PINS = 16
)
(
  input wire logic            clock,
  input wire logic            rst_b,
  input wire logic            read,
  input wire logic            write,
  input wire logic            waitrequest,
  input wire logic [2:0]      match_a,
  input wire logic [2:0]      match_b,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic [PINS-1:0] alt_func_en,
  input wire logic [PINS-1:0] pattern_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_active_drives: assert property (~|(pattern_active & ~pin_oe))
    else $error("pattern pin not driven");
  a_alt_blocks: assert property (~|(pattern_active & $past(alt_func_en)))
    else $error("pattern on shared pin");
  a_alt_undriven: assert property (~|(pin_oe & $past(alt_func_en)))
    else $error("port drives shared pin");
  a_out_cause: assert property ((pin_out != $past(pin_out)) |->
    ($past(match_a) != 3'h0 || $past(match_b) != 3'h0 || $past(write)))
    else $error("output moved without cause");
  a_b_only_falls: assert property ($past(match_b) != 3'h0 && $past(match_a) == 3'h0
    && !$past(write) |-> ~|(pin_out & ~$past(pin_out)))
    else $error("rise on match B");
  // Exactly one wait state per access
  a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer");
  a_wait_short: assert property (!waitrequest |=> waitrequest)
    else $error("answer too long");
  a_idle_quiet: assert property (!(read || write) |=> waitrequest)
    else $error("answer without request");
endmodule : pattern_output_unit_props
bind pattern_output_unit pattern_output_unit_props #(.PINS(PINS)) props (.clock, .rst_b,
  .read, .write, .waitrequest, .match_a, .match_b, .pin_out, .pin_oe, .alt_func_en,
  .pattern_active);
`default_nettype wire

// [verification/pin_load_model.sv]
// External loads on the pattern pins
`default_nettype none
module pin_load_model
(
  // Device side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  // Level the loads put on pins left undriven
  input  wire logic [15:0] ext,
  output var  logic [15:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven pins show the load level, never a held copy of the last output
  assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule : pin_load_model
`default_nettype wire

// [verification/timed_pattern_output_bench.sv]
// Self-checking bench of the pattern output unit
`default_nettype none
module timed_pattern_output_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_b, read, write, waitrequest;
  logic [3:0] address;
  logic [31:0] writedata, readdata, q;
  logic [2:0] match_a, match_b;
  logic [15:0] pin_in, pin_out, pin_oe, alt_func_en, pattern_active, ext, st, old;
  int err_count, cmp_count, ch;
  logic [31:0] seed = 32'h017C8ADA;
  pattern_output_unit uut (.clock, .rst_b, .address, .read, .write, .writedata,
    .byteenable(4'hF), .readdata, .waitrequest, .match_a, .match_b, .pin_in, .pin_out,
    .pin_oe, .alt_func_en, .pattern_active);
  pin_load_model loads (.pin_out, .pin_oe, .ext, .pin_in);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Codes 10 and 11 both pick the last channel
  function automatic int chan(input int c);
    return c > 1 ? 2 : c;
  endfunction : chan
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {24'h0, d};
    // Only the watchdog ends a wait for an answer that never comes
    do
    begin
      @(posedge clock);
    end
    while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc
  task automatic stage();
    st = 16'(rnd());
    acc(1'b1, pattern_output_pkg::ADDR_LOW_STAGED, st[7:0]);
    acc(1'b1, pattern_output_pkg::ADDR_HIGH_STAGED, st[15:8]);
  endtask : stage
  task automatic pulse(input logic [2:0] a, input logic [2:0] b);
    @(posedge clock);
    match_a <= a;
    match_b <= b;
    @(posedge clock);
    match_a <= 3'h0;
    match_b <= 3'h0;
    @(negedge clock);
  endtask : pulse
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Whole run needs about two hundred cycles
  initial
  begin
    #200000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    rst_b = 1'b0;
    {read, write, address, writedata, match_a, match_b, alt_func_en} = '0;
    ext = 16'(rnd());
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    acc(1'b0, pattern_output_pkg::ADDR_TRIG_SEL, 8'h00);
    chk(q, 32'h000000FF);
    acc(1'b0, 4'hC, 8'h00);
    chk(q, 32'h00000000);
    acc(1'b1, pattern_output_pkg::ADDR_LATCH_A, 8'h5A);
    acc(1'b1, pattern_output_pkg::ADDR_LATCH_B, 8'hC3);
    acc(1'b1, pattern_output_pkg::ADDR_DIR_A, 8'hFF);
    acc(1'b1, pattern_output_pkg::ADDR_DIR_B, 8'hFF);
    repeat (2) @(negedge clock);
    chk(pin_oe, 16'hFFFF);
    chk(pattern_active, 16'h0000);
    acc(1'b1, pattern_output_pkg::ADDR_LOW_ENABLE, 8'hFF);
    acc(1'b1, pattern_output_pkg::ADDR_HIGH_ENABLE, 8'hFF);
    acc(1'b1, pattern_output_pkg::ADDR_LATCH_A, 8'h00);
    acc(1'b0, pattern_output_pkg::ADDR_LATCH_A, 8'h00);
    chk(q, 32'h0000005A);
    chk(pin_out, 16'hC35A);
    chk(pattern_active, 16'hFFFF);
    old = pin_out;
    for (int c = 0; c < 4; c++)
    begin
      ch = chan(c);
      acc(1'b1, pattern_output_pkg::ADDR_TRIG_SEL, {4{c[1:0]}});
      stage();
      pulse(~(3'h1 << ch), 3'h7);
      chk(pin_out, old);
      pulse(3'h1 << ch, 3'h0);
      chk(pin_out, st);
      old = st;
    end
    acc(1'b1, pattern_output_pkg::ADDR_OVERLAP_MODE, 8'h0F);
    repeat (4)
    begin
      stage();
      pulse(3'h0, 3'h4);
      chk(pin_out, old & st);
      pulse(3'h4, 3'h0);
      chk(pin_out, st);
      old = st;
    end
    // Both matches in one cycle: match A copies every bit
    stage();
    pulse(3'h4, 3'h4);
    chk(pin_out, st);
    old = st;
    acc(1'b1, pattern_output_pkg::ADDR_DIR_B, 8'h00);
    alt_func_en <= 16'h00F0;
    stage();
    pulse(3'h4, 3'h0);
    acc(1'b0, pattern_output_pkg::ADDR_LATCH_B, 8'h00);
    chk(q, {24'h0, st[15:8]});
    chk(pin_out, st);
    chk(pin_oe, 16'h000F);
    chk(pattern_active, 16'h000F);
    acc(1'b0, pattern_output_pkg::ADDR_PIN_STATE, 8'h00);
    chk(q, {16'h0, (st & 16'h000F) | (ext & 16'hFFF0)});
    acc(1'b0, pattern_output_pkg::ADDR_ALT_FUNC, 8'h00);
    chk(q, 32'h000000F0);
    report_and_stop();
  end
endmodule : timed_pattern_output_bench
`default_nettype wire
